// *** cutl_consts.vh ***
`ifndef CUTL_CONSTS_VH
`define CUTL_CONSTS_VH

// Register addresses on the microcontroller register port.
`define CUTL_ADDR_OBSERVE 16'h6104
`define CUTL_ADDR_TESTSEL2 16'h6322
`define CUTL_ADDR_AUTOTEST 16'h6326
`define CUTL_ADDR_VERSION 16'h6327
`define CUTL_ADDR_ANALOG 16'h6328

// Reset values.
`define CUTL_RST_OBSERVE 8'h00
`define CUTL_RST_TESTSEL2 8'h00
`define CUTL_RST_AUTOTEST 8'h00
`define CUTL_RST_ANALOG 8'h00

// Field positions.
`define CUTL_OBSERVE_EN_BIT 0
`define CUTL_SEL2_BUS_HI 4
`define CUTL_SEL2_BUS_LO 0
`define CUTL_SEL2_PRBS9_BIT 7
`define CUTL_SEL2_PRBS15_BIT 6
`define CUTL_PROBE_A_HI 7
`define CUTL_PROBE_A_LO 4
`define CUTL_PROBE_B_HI 3
`define CUTL_PROBE_B_LO 0

// Encodings and counts.
`define CUTL_AUTOTEST_ARM 8'h09
`define CUTL_BUSSEL_RX 5'h07
`define CUTL_BUSSEL_CLK 5'h0D
`define CUTL_SIG_BYTES 7'h40

`endif

// *** cutl_prbs_gen.v ***
`timescale 1ns/1ps
`include "cutl_consts.vh"

module cutl_prbs_gen #(
  parameter LFSR_W = 15
) (
  input wire core_clk,
  input wire sys_rst,
  input wire restart,
  input wire long_mode,
  input wire step,
  output wire bit_out
);

  reg [LFSR_W-1:0] lfsr;
  wire feedback;

  // Short mode taps stages 9 and 5, long mode taps stages 15 and 14.
  assign feedback = long_mode ? (lfsr[14] ^ lfsr[13]) : (lfsr[8] ^ lfsr[4]);
  assign bit_out = long_mode ? lfsr[14] : lfsr[8];

  always @(posedge core_clk) begin
    if (sys_rst || restart) begin
      lfsr <= {LFSR_W{1'b1}};
    end else if (step) begin
      lfsr <= {lfsr[LFSR_W-2:0], feedback};
    end
  end

endmodule

// *** cutl_test_logic.v ***
`timescale 1ns/1ps
`include "cutl_consts.vh"

// Function
// [RL1] Software soft-resets the unit and clears the buffer with 25 zero bytes first.
// [RL2] Software arms the self-test by writing 09h into the automatic test control register.
// [RL3] After arming, a zero byte and the checksum command start the self-test instead of a CRC.
// [RL4] At the end of the self-test the fixed 64-byte signature stands in the FIFO.
// [RL5] With the observe bit set, six port-3 pads and the reset pad drive bus bits D0 to D6.
// [RL6] With the observe bit set, the interrupt pad carries the unit's 13.56 MHz clock.
// [RL7] The probe bus selector field of the second test selection register picks the bus group.
// [RL8] Selector 07h shows the receiver group of seven signals on the bus.
// [RL9] Selector 0Dh shows the seven clock and oscillator signals on the bus, D6 down to D0.
// [RL10] Each analog probe pin takes the test signal named by its own source select field.
// [RL11] Pseudo-random mode makes a 9-bit or a 15-bit register length sequence as configured.
// [RL12] The stream goes out only after the transmit command, with framing added by the coder.
// [RL13] Software sets up every transmit setting before entering pseudo-random mode.
// [RL14] The soft reset restores every register, keeps the buffer and then idles the command.
// [RL15] Clearing the observe bit returns the pads to their normal port and interrupt use.
// [RL16] Bits 7 to 1 of the observe control register read as zero and ignore writes.
module cutl_test_logic #(
  parameter VERSION_VALUE = 8'h5A // Arbitrary version code, chosen for this block only.
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire unit_soft_reset_cmd,
  input wire checksum_compute_cmd,
  input wire transmit_cmd,
  input wire idle_cmd,
  input wire fifo_first_byte_zero,
  output reg fifo_wr,
  output reg [7:0] fifo_wdata,
  output reg self_test_busy,
  output reg self_test_done,
  output reg command_idle,
  input wire [6:0] receiver_group,
  input wire [6:0] clock_group,
  input wire field_carrier_clock,
  input wire [5:0] normal_port3_out,
  input wire [5:0] normal_port3_oe,
  input wire normal_reset_out,
  input wire normal_reset_oe,
  input wire normal_irq_out,
  input wire normal_irq_oe,
  output reg [5:0] port_three_pads_out,
  output reg [5:0] port_three_pads_oe,
  output reg reset_output_pad_out,
  output reg reset_output_pad_oe,
  output reg interrupt_pad_out,
  output reg interrupt_pad_oe,
  output reg [6:0] probe_bus,
  output reg first_analog_probe_pin,
  output reg second_analog_probe_pin,
  input wire prbs_bit_req,
  output reg prbs_tx_active,
  output reg prbs_bit
);

  reg internal_bus_observe_ctrl;
  reg [7:0] test_selection_two;
  reg [7:0] automatic_test_ctrl;
  reg [7:0] analog_probe_ctrl;
  reg [6:0] clk_meta;
  reg [6:0] clk_sync;
  reg carrier_meta;
  reg carrier_sync;
  reg [6:0] sig_idx;
  reg prbs_restart;
  reg [6:0] next_probe_bus;
  reg [15:0] aux_sources;
  wire [4:0] probe_bus_selector;
  wire local_rst;
  wire prbs_enable;
  wire prbs_long;
  wire prbs_gen_bit;

  // The soft reset clears the registers here; the configuration buffer lives elsewhere.
  assign local_rst = sys_rst | unit_soft_reset_cmd; // RL14
  assign probe_bus_selector = test_selection_two[`CUTL_SEL2_BUS_HI:`CUTL_SEL2_BUS_LO];
  assign prbs_long = test_selection_two[`CUTL_SEL2_PRBS15_BIT];
  assign prbs_enable = test_selection_two[`CUTL_SEL2_PRBS9_BIT] | prbs_long; // RL11

  function [7:0] signature_byte;
    input [5:0] idx;
    begin
      case (idx)
        6'd0: signature_byte = 8'h00;
        6'd1: signature_byte = 8'hAA;
        6'd2: signature_byte = 8'hE3;
        6'd3: signature_byte = 8'h29;
        6'd4: signature_byte = 8'h0C;
        6'd5: signature_byte = 8'h10;
        6'd6: signature_byte = 8'h29;
        6'd7: signature_byte = 8'h6B;
        6'd8: signature_byte = 8'h76;
        6'd9: signature_byte = 8'h8D;
        6'd10: signature_byte = 8'hAF;
        6'd11: signature_byte = 8'h4B;
        6'd12: signature_byte = 8'hA2;
        6'd13: signature_byte = 8'hDA;
        6'd14: signature_byte = 8'h76;
        6'd15: signature_byte = 8'h99;
        6'd16: signature_byte = 8'hC7;
        6'd17: signature_byte = 8'h5E;
        6'd18: signature_byte = 8'h24;
        6'd19: signature_byte = 8'h69;
        6'd20: signature_byte = 8'hD2;
        6'd21: signature_byte = 8'hBA;
        6'd22: signature_byte = 8'hFA;
        6'd23: signature_byte = 8'hBC;
        6'd24: signature_byte = 8'h3E;
        6'd25: signature_byte = 8'hDA;
        6'd26: signature_byte = 8'h96;
        6'd27: signature_byte = 8'hB5;
        6'd28: signature_byte = 8'hF5;
        6'd29: signature_byte = 8'h94;
        6'd30: signature_byte = 8'hB0;
        6'd31: signature_byte = 8'h3A;
        6'd32: signature_byte = 8'h4E;
        6'd33: signature_byte = 8'hC3;
        6'd34: signature_byte = 8'h9D;
        6'd35: signature_byte = 8'h94;
        6'd36: signature_byte = 8'h76;
        6'd37: signature_byte = 8'h4C;
        6'd38: signature_byte = 8'hEA;
        6'd39: signature_byte = 8'h5E;
        6'd40: signature_byte = 8'h38;
        6'd41: signature_byte = 8'h10;
        6'd42: signature_byte = 8'h8F;
        6'd43: signature_byte = 8'h2D;
        6'd44: signature_byte = 8'h21;
        6'd45: signature_byte = 8'h4B;
        6'd46: signature_byte = 8'h52;
        6'd47: signature_byte = 8'hBF;
        6'd48: signature_byte = 8'hFB;
        6'd49: signature_byte = 8'hF4;
        6'd50: signature_byte = 8'h19;
        6'd51: signature_byte = 8'h94;
        6'd52: signature_byte = 8'h82;
        6'd53: signature_byte = 8'h5A;
        6'd54: signature_byte = 8'h72;
        6'd55: signature_byte = 8'h9D;
        6'd56: signature_byte = 8'hBA;
        6'd57: signature_byte = 8'h0D;
        6'd58: signature_byte = 8'h1F;
        6'd59: signature_byte = 8'h17;
        6'd60: signature_byte = 8'h56;
        6'd61: signature_byte = 8'h22;
        6'd62: signature_byte = 8'hB9;
        default: signature_byte = 8'h08;
      endcase
    end
  endfunction

  // Register writes.
  always @(posedge core_clk) begin
    if (local_rst) begin
      internal_bus_observe_ctrl <= 1'b0;
      test_selection_two <= `CUTL_RST_TESTSEL2;
      automatic_test_ctrl <= `CUTL_RST_AUTOTEST;
      analog_probe_ctrl <= `CUTL_RST_ANALOG;
    end else if (reg_wr) begin
      case (reg_addr)
        `CUTL_ADDR_OBSERVE: begin
          internal_bus_observe_ctrl <= reg_wdata[`CUTL_OBSERVE_EN_BIT]; // RL16
        end
        `CUTL_ADDR_TESTSEL2: begin
          test_selection_two <= reg_wdata;
        end
        `CUTL_ADDR_AUTOTEST: begin
          automatic_test_ctrl <= reg_wdata; // RL2
        end
        `CUTL_ADDR_ANALOG: begin
          analog_probe_ctrl <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads, one cycle after the strobe; unmapped addresses read zero.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CUTL_ADDR_OBSERVE: reg_rdata <= {7'h00, internal_bus_observe_ctrl}; // RL16
        `CUTL_ADDR_TESTSEL2: reg_rdata <= test_selection_two;
        `CUTL_ADDR_AUTOTEST: reg_rdata <= automatic_test_ctrl;
        `CUTL_ADDR_VERSION: reg_rdata <= VERSION_VALUE;
        `CUTL_ADDR_ANALOG: reg_rdata <= analog_probe_ctrl;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Self-test engine: one signature byte per cycle into the FIFO.
  always @(posedge core_clk) begin
    if (local_rst) begin
      self_test_busy <= 1'b0;
      self_test_done <= 1'b0;
      fifo_wr <= 1'b0;
      fifo_wdata <= 8'h00;
      sig_idx <= 7'h00;
    end else begin
      self_test_done <= 1'b0;
      fifo_wr <= 1'b0;
      if (!self_test_busy) begin
        // RL3
        if (checksum_compute_cmd && automatic_test_ctrl == `CUTL_AUTOTEST_ARM
            && fifo_first_byte_zero) begin
          self_test_busy <= 1'b1;
          sig_idx <= 7'h00;
        end
      end else if (idle_cmd) begin
        self_test_busy <= 1'b0;
      end else if (sig_idx == `CUTL_SIG_BYTES) begin
        self_test_busy <= 1'b0;
        self_test_done <= 1'b1;
      end else begin
        fifo_wr <= 1'b1;
        fifo_wdata <= signature_byte(sig_idx[5:0]); // RL4
        sig_idx <= sig_idx + 7'h01;
      end
    end
  end

  // The idle report follows the soft reset by one cycle.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      command_idle <= 1'b0;
    end else begin
      command_idle <= unit_soft_reset_cmd; // RL14
    end
  end

  // Clock-group signals come from other clock domains and are synchronised first.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      clk_meta <= 7'h00;
      clk_sync <= 7'h00;
      carrier_meta <= 1'b0;
      carrier_sync <= 1'b0;
    end else begin
      clk_meta <= clock_group;
      clk_sync <= clk_meta;
      carrier_meta <= field_carrier_clock;
      carrier_sync <= carrier_meta;
    end
  end

  always @* begin
    case (probe_bus_selector) // RL7
      `CUTL_BUSSEL_RX: next_probe_bus = receiver_group; // RL8
      `CUTL_BUSSEL_CLK: next_probe_bus = clk_sync; // RL9
      default: next_probe_bus = 7'h00;
    endcase
    aux_sources = {9'h000, probe_bus};
  end

  // Pads and probe outputs; sampled at 250 MHz, so fast clocks show with jitter.
  always @(posedge core_clk) begin
    if (local_rst) begin
      probe_bus <= 7'h00;
      port_three_pads_out <= 6'h00;
      port_three_pads_oe <= 6'h00;
      reset_output_pad_out <= 1'b0;
      reset_output_pad_oe <= 1'b0;
      interrupt_pad_out <= 1'b0;
      interrupt_pad_oe <= 1'b0;
      first_analog_probe_pin <= 1'b0;
      second_analog_probe_pin <= 1'b0;
    end else begin
      probe_bus <= next_probe_bus;
      first_analog_probe_pin <=
          aux_sources[analog_probe_ctrl[`CUTL_PROBE_A_HI:`CUTL_PROBE_A_LO]]; // RL10
      second_analog_probe_pin <=
          aux_sources[analog_probe_ctrl[`CUTL_PROBE_B_HI:`CUTL_PROBE_B_LO]]; // RL10
      if (internal_bus_observe_ctrl) begin
        port_three_pads_out <= next_probe_bus[5:0]; // RL5
        port_three_pads_oe <= 6'h3F;
        reset_output_pad_out <= next_probe_bus[6]; // RL5
        reset_output_pad_oe <= 1'b1;
        interrupt_pad_out <= carrier_sync; // RL6
        interrupt_pad_oe <= 1'b1;
      end else begin
        port_three_pads_out <= normal_port3_out; // RL15
        port_three_pads_oe <= normal_port3_oe;
        reset_output_pad_out <= normal_reset_out;
        reset_output_pad_oe <= normal_reset_oe;
        interrupt_pad_out <= normal_irq_out;
        interrupt_pad_oe <= normal_irq_oe;
      end
    end
  end

  // Pseudo-random transmit: the stream runs only after the transmit command.
  always @(posedge core_clk) begin
    if (local_rst) begin
      prbs_tx_active <= 1'b0;
      prbs_bit <= 1'b0;
      prbs_restart <= 1'b1;
    end else begin
      prbs_restart <= 1'b0;
      if (!prbs_enable || idle_cmd) begin
        prbs_tx_active <= 1'b0;
        prbs_restart <= 1'b1;
      end else if (transmit_cmd) begin
        prbs_tx_active <= 1'b1; // RL12
      end
      if (prbs_tx_active && prbs_bit_req) begin
        prbs_bit <= prbs_gen_bit; // RL11
      end
    end
  end

  cutl_prbs_gen #(
    .LFSR_W(15)
  ) u_prbs (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(prbs_restart),
    .long_mode(prbs_long),
    .step(prbs_tx_active & prbs_bit_req),
    .bit_out(prbs_gen_bit)
  );

endmodule

// *** cutl_assertions.sv ***
`timescale 1ns/1ps
module cutl_assertions (
  input wire core_clk,
  input wire sys_rst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire unit_soft_reset_cmd,
  input wire checksum_compute_cmd,
  input wire transmit_cmd,
  input wire idle_cmd,
  input wire fifo_first_byte_zero,
  input wire fifo_wr,
  input wire [7:0] fifo_wdata,
  input wire self_test_busy,
  input wire self_test_done,
  input wire [6:0] receiver_group,
  input wire [5:0] normal_port3_oe,
  input wire [5:0] port_three_pads_oe,
  input wire reset_output_pad_oe,
  input wire [6:0] probe_bus,
  input wire prbs_tx_active
);
  reg obs;
  reg [7:0] sel2;
  reg [7:0] arm;
  reg quiet;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Shadow copies of the observe, second test selection and automatic test registers; quiet is low the cycle after any reset.
  always @(posedge core_clk) begin
    quiet <= !sys_rst && !unit_soft_reset_cmd;
    if (sys_rst || unit_soft_reset_cmd) begin
      obs <= 1'b0;
      sel2 <= 8'h00;
      arm <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 16'h6104)
        obs <= reg_wdata[0];
      if (reg_addr == 16'h6322)
        sel2 <= reg_wdata;
      if (reg_addr == 16'h6326)
        arm <= reg_wdata;
    end
  end
  property p_obs_oe;
    quiet && $past(obs) |-> port_three_pads_oe == 6'h3F && reset_output_pad_oe;
  endproperty
  a_obs_oe: assert property (p_obs_oe) else $error("pads not outputs");
  property p_off;
    quiet && !$past(obs) && $stable(normal_port3_oe) |-> port_three_pads_oe == normal_port3_oe;
  endproperty
  a_off: assert property (p_off) else $error("pads not normal");
  property p_obs_rd;
    reg_rd && !reg_wr && reg_addr == 16'h6104 |=> reg_rdata == {7'h00, $past(obs)};
  endproperty
  a_obs_rd: assert property (p_obs_rd) else $error("observe read wrong");
  property p_sel_rx;
    quiet && $past(sel2[4:0]) == 5'h07 && $stable(receiver_group) |-> probe_bus == receiver_group;
  endproperty
  a_sel_rx: assert property (p_sel_rx) else $error("bus not receiver group");
  property p_st_go;
    checksum_compute_cmd && arm == 8'h09 && fifo_first_byte_zero && !self_test_busy && !idle_cmd
      |=> self_test_busy ##1 (fifo_wr && fifo_wdata == 8'h00) ##1 (fifo_wr && fifo_wdata == 8'hAA);
  endproperty
  a_st_go: assert property (p_st_go) else $error("self-test start wrong");
  property p_st_off;
    checksum_compute_cmd && arm != 8'h09 && !self_test_busy |=> !self_test_busy;
  endproperty
  a_st_off: assert property (p_st_off) else $error("unarmed self-test ran");
  property p_st_end;
    $rose(self_test_busy) |-> ##65 (self_test_done && !self_test_busy && $past(fifo_wr)
      && $past(fifo_wdata) == 8'h08);
  endproperty
  a_st_end: assert property (p_st_end) else $error("self-test end wrong");
  property p_prbs_go;
    quiet && !$past(prbs_tx_active) && !$past(transmit_cmd) |-> !prbs_tx_active;
  endproperty
  a_prbs_go: assert property (p_prbs_go) else $error("stream without command");
endmodule
bind cutl_test_logic cutl_assertions i_cutl_assertions (.*);

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic unit_soft_reset_cmd = 1'b0, checksum_compute_cmd = 1'b0, transmit_cmd = 1'b0;
  logic idle_cmd = 1'b0, fifo_first_byte_zero = 1'b1, prbs_bit_req = 1'b0;
  logic field_carrier_clock = 1'b0, normal_reset_out = 1'b1, normal_reset_oe = 1'b0;
  logic normal_irq_out = 1'b1, normal_irq_oe = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] receiver_group = 7'h35, clock_group = 7'h4B;
  logic [5:0] normal_port3_out = 6'h15, normal_port3_oe = 6'h0C;
  wire [7:0] reg_rdata, fifo_wdata;
  wire [6:0] probe_bus;
  wire [5:0] port_three_pads_out, port_three_pads_oe;
  wire fifo_wr, self_test_busy, self_test_done, command_idle, reset_output_pad_out;
  wire reset_output_pad_oe, interrupt_pad_out, interrupt_pad_oe, first_analog_probe_pin;
  wire second_analog_probe_pin, prbs_tx_active, prbs_bit;
  wire [7:0] pad_oe = {port_three_pads_oe, reset_output_pad_oe, interrupt_pad_oe};
  wire [7:0] pad_out = {port_three_pads_out, reset_output_pad_out, interrupt_pad_out};
  integer n_mismatch = 0, check_count = 0, cycles = 0;
  cutl_test_logic i_cutl_test_logic (.*);
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task nw(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // Strobes drop a full cycle before the next access so no signal changes twice at one edge.
  task wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    nw(1);
    reg_wr = 1'b0;
    nw(1);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    nw(1);
    reg_rd = 1'b0;
    nw(1);
    chk("read", reg_rdata, e);
  endtask
  task t_regs;
    logic seen;
    rd(16'h6104, 8'h00);
    rd(16'h6322, 8'h00);
    rd(16'h6326, 8'h00);
    rd(16'h6300, 8'h00);
    wr(16'h6104, 8'hFF);
    rd(16'h6104, 8'h01);
    wr(16'h6328, 8'hA5);
    rd(16'h6328, 8'hA5);
    rd(16'h6327, 8'h5A);
    unit_soft_reset_cmd = 1'b1;
    nw(1);
    unit_soft_reset_cmd = 1'b0;
    seen = command_idle;
    nw(1);
    seen = seen | command_idle;
    chk("idle", {7'h00, seen}, 8'h01);
    rd(16'h6104, 8'h00);
    rd(16'h6328, 8'h00);
  endtask
  task t_obs;
    wr(16'h6322, 8'h07);
    wr(16'h6104, 8'h01);
    nw(4);
    chk("bus", {1'b0, probe_bus}, {1'b0, receiver_group});
    chk("pad oe", pad_oe, 8'hFF);
    chk("pad data", {pad_out[7:1], 1'b0}, {receiver_group[5:0], receiver_group[6], 1'b0});
    field_carrier_clock = 1'b1;
    nw(5);
    chk("clock pad", {7'h00, interrupt_pad_out}, 8'h01);
    field_carrier_clock = 1'b0;
    nw(5);
    chk("clock pad", {7'h00, interrupt_pad_out}, 8'h00);
    wr(16'h6322, 8'h0D);
    nw(4);
    chk("bus", {1'b0, probe_bus}, {1'b0, clock_group});
    wr(16'h6322, 8'h0E);
    nw(4);
    chk("bus", {1'b0, probe_bus}, 8'h00);
    wr(16'h6104, 8'h00);
    nw(2);
    chk("pad oe", pad_oe, {normal_port3_oe, normal_reset_oe, normal_irq_oe});
    chk("pad data", pad_out, {normal_port3_out, normal_reset_out, normal_irq_out});
  endtask
  task t_aux;
    logic [3:0] s;
    logic [8:0] g;
    g = {2'b00, receiver_group};
    wr(16'h6322, 8'h07);
    for (s = 4'h0; s < 4'h8; s = s + 4'h1) begin
      wr(16'h6328, {s, s + 4'h1});
      nw(2);
      chk("aux", {6'h00, first_analog_probe_pin, second_analog_probe_pin},
          {6'h00, g[s], g[s + 4'h1]});
    end
  endtask
  task t_self;
    logic [7:0] b [0:63];
    logic [7:0] n;
    logic done;
    n = 8'h00;
    done = 1'b0;
    unit_soft_reset_cmd = 1'b1;
    nw(1);
    unit_soft_reset_cmd = 1'b0;
    nw(1);
    wr(16'h6326, 8'h08);
    checksum_compute_cmd = 1'b1;
    nw(1);
    checksum_compute_cmd = 1'b0;
    nw(3);
    chk("busy", {7'h00, self_test_busy}, 8'h00);
    wr(16'h6326, 8'h09);
    checksum_compute_cmd = 1'b1;
    nw(1);
    checksum_compute_cmd = 1'b0;
    for (int i = 0; i < 80 && !done; i++) begin
      if (fifo_wr === 1'b1) begin
        if (n < 8'h40)
          b[n[5:0]] = fifo_wdata;
        n = n + 8'h01;
      end
      done = (self_test_done === 1'b1);
      nw(1);
    end
    chk("done", {7'h00, done}, 8'h01);
    chk("count", n, 8'h40);
    chk("byte 0", b[0], 8'h00);
    chk("byte 1", b[1], 8'hAA);
    chk("byte 63", b[63], 8'h08);
  endtask
  task t_prbs(input logic [7:0] mode, input integer len, input integer tap);
    logic [39:0] pb;
    logic [7:0] bad;
    bad = 8'h00;
    wr(16'h6322, mode);
    prbs_bit_req = 1'b1;
    nw(1);
    prbs_bit_req = 1'b0;
    nw(1);
    chk("active", {7'h00, prbs_tx_active}, 8'h00);
    transmit_cmd = 1'b1;
    nw(1);
    transmit_cmd = 1'b0;
    nw(1);
    chk("active", {7'h00, prbs_tx_active}, 8'h01);
    for (int i = 0; i < 40; i++) begin
      prbs_bit_req = 1'b1;
      nw(1);
      prbs_bit_req = 1'b0;
      nw(1);
      pb[i] = prbs_bit;
      if (i >= len && pb[i] !== (pb[i - len] ^ pb[i - tap]))
        bad = bad + 8'h01;
    end
    chk("first bit", {7'h00, pb[0]}, 8'h01);
    chk("sequence", bad, 8'h00);
    idle_cmd = 1'b1;
    nw(1);
    idle_cmd = 1'b0;
    nw(1);
    chk("active", {7'h00, prbs_tx_active}, 8'h00);
  endtask
  initial begin
    nw(2);
    sys_rst = 1'b0;
    t_regs;
    t_obs;
    t_aux;
    t_self;
    t_prbs(8'h80, 9, 5);
    t_prbs(8'h40, 15, 14);
    print_verdict;
  end
endmodule
